// ### adcrr_bank.sv
// Result slot register bank: three slots written by the sequencer, read by software.
// Assumes one clock, synchronous strobes, reads answered one cycle after the strobe.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - Slot holds 10-bit value in bits 15:6
// - Overwrite flag sets on unread overwrite
// - Reading slot clears overwrite flag
// - Stored flag sets when result written
// - Reading slot clears stored flag
// - Writing 10 then 01 resets all
module adcrr_bank #(
  parameter int NUM_SLOTS = 3,
  parameter int SLOT_SRC_ONE = 0,
  parameter int SLOT_SRC_TWO = 1,
  parameter int SLOT_SRC_THREE = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Sequencer store ports, one per source
  input adcrr_pkg::adcrr_store_t store_in [3],
  // Interrupt
  output logic irq
);
  import adcrr_pkg::*;

  // Refuse configurations the fixed three-slot logic cannot serve
  if (NUM_SLOTS != 3 || SLOT_SRC_ONE < 0 || SLOT_SRC_ONE > 2 || SLOT_SRC_TWO < 0
    || SLOT_SRC_TWO > 2 || SLOT_SRC_THREE < 0 || SLOT_SRC_THREE > 2)
  begin : g_bad_cfg
    $error("adcrr_bank: unsupported slot configuration");
  end

  // Slot address decode, -1 when not a slot
  function automatic int slot_of(input logic [7:0] addr);
    case (addr)
      ADCRR_SLOT_ONE_ADDR: slot_of = 0;
      ADCRR_SLOT_TWO_ADDR: slot_of = 1;
      ADCRR_SLOT_THREE_ADDR: slot_of = 2;
      default: slot_of = -1;
    endcase
  endfunction : slot_of

  localparam int SRC_MAP [3] = '{SLOT_SRC_ONE, SLOT_SRC_TWO, SLOT_SRC_THREE};

  adcrr_slot_t slot [3];
  logic srst_armed;
  logic soft_reset;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [2:0] slot_store;
  logic [2:0] slot_read;

  // Soft reset sequence detect
  assign soft_reset = reg_wr && reg_addr == ADCRR_SOFT_RESET_ADDR && srst_armed
    && reg_wdata[1:0] == ADCRR_SRST_FIRE;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      srst_armed <= 1'b0;
    end
    else if (reg_wr && reg_addr == ADCRR_SOFT_RESET_ADDR)
    begin
      srst_armed <= reg_wdata[1:0] == ADCRR_SRST_ARM;
    end
  end

  // Per-slot store and read decode, then slot state
  generate
    for (genvar i = 0; i < 3; i++)
    begin : g_slot
      assign slot_store[i] = store_in[SRC_MAP[i]].store;
      assign slot_read[i] = reg_rd && slot_of(reg_addr) == i;

      always_ff @(posedge sys_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          slot[i] <= adcrr_slot_t'(ADCRR_SLOT_RESET[11:0]);
        end
        else if (soft_reset)
        begin
          slot[i] <= adcrr_slot_t'(ADCRR_SLOT_RESET[11:0]);
        end
        else if (slot_store[i])
        begin
          slot[i].value <= store_in[SRC_MAP[i]].value;
          slot[i].stored <= 1'b1;
          // Store wins over a same-cycle read
          slot[i].overwrite <= slot[i].stored | (slot[i].overwrite & ~slot_read[i]);
        end
        else if (slot_read[i])
        begin
          slot[i].overwrite <= 1'b0;
          slot[i].stored <= 1'b0;
        end
      end
    end
  endgenerate

  // Interrupt status, mask and output
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_status <= ADCRR_IRQ_RESET;
      irq_mask <= ADCRR_IRQ_RESET;
    end
    else if (soft_reset)
    begin
      irq_status <= ADCRR_IRQ_RESET;
      irq_mask <= ADCRR_IRQ_RESET;
    end
    else
    begin
      if (reg_wr && reg_addr == ADCRR_IRQ_STATUS_ADDR)
      begin
        irq_status <= (irq_status & ~reg_wdata[2:0]) | slot_store;
      end
      else
      begin
        irq_status <= irq_status | slot_store;
      end
      if (reg_wr && reg_addr == ADCRR_IRQ_MASK_ADDR)
      begin
        irq_mask <= reg_wdata[2:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(next_irq_bits());
    end
  end

  // Masked status as it will stand after this edge
  function automatic logic [2:0] next_irq_bits();
    logic [2:0] st;
    st = irq_status | slot_store;
    if (soft_reset)
    begin
      st = ADCRR_IRQ_RESET;
    end
    else if (reg_wr && reg_addr == ADCRR_IRQ_STATUS_ADDR)
    begin
      st = (irq_status & ~reg_wdata[2:0]) | slot_store;
    end
    if (soft_reset)
    begin
      next_irq_bits = st;
    end
    else if (reg_wr && reg_addr == ADCRR_IRQ_MASK_ADDR)
    begin
      next_irq_bits = st & reg_wdata[2:0];
    end
    else
    begin
      next_irq_bits = st & irq_mask;
    end
  endfunction : next_irq_bits

  // Read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_rdata <= 32'h0000_0000;
    end
    else if (reg_rd)
    begin
      reg_rdata <= 32'h0000_0000;
      case (reg_addr)
        ADCRR_SLOT_ONE_ADDR, ADCRR_SLOT_TWO_ADDR, ADCRR_SLOT_THREE_ADDR:
        begin
          reg_rdata[ADCRR_VALUE_MSB:ADCRR_VALUE_LSB] <= slot[slot_of(reg_addr)].value;
          reg_rdata[ADCRR_OVERWRITE_BIT] <= slot[slot_of(reg_addr)].overwrite;
          reg_rdata[ADCRR_STORED_BIT] <= slot[slot_of(reg_addr)].stored;
        end
        ADCRR_IRQ_STATUS_ADDR: reg_rdata[2:0] <= irq_status;
        ADCRR_IRQ_MASK_ADDR: reg_rdata[2:0] <= irq_mask;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
    begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // Checks on slot and interrupt behaviour, all on the bank clock
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // Store side: flag set per slot, value capture on slots one and three
  stored_set_a: assert property (slot_store[0] && !soft_reset |=> slot[0].stored)
    else $error("stored flag not set after store");
  stored_set_two_a: assert property (slot_store[1] && !soft_reset |=> slot[1].stored)
    else $error("stored flag two not set after store");
  stored_set_three_a: assert property (slot_store[2] && !soft_reset |=> slot[2].stored)
    else $error("stored flag three not set after store");
  value_update_a: assert property (
    slot_store[2] && !soft_reset |=> slot[2].value == $past(store_in[SRC_MAP[2]].value))
    else $error("value not captured");
  value_one_a: assert property (
    slot_store[0] && !soft_reset |=> slot[0].value == $past(store_in[SRC_MAP[0]].value))
    else $error("value one not captured");
  value_hold_a: assert property (
    !slot_store[1] && !soft_reset |=> slot[1].value == $past(slot[1].value))
    else $error("value two changed without a store");
  store_port_a: assert property (
    !store_in[SRC_MAP[0]].store && !slot_read[0] && !soft_reset
    |=> slot[0].stored == $past(slot[0].stored))
    else $error("slot fed by wrong port");
  store_port_two_a: assert property (
    !store_in[SRC_MAP[1]].store && !slot_read[1] && !soft_reset
    |=> slot[1].stored == $past(slot[1].stored))
    else $error("slot two fed by wrong port");

  // Overwrite flag: set on unread overwrite, cleared on read
  overwrite_set_a: assert property (
    slot[1].stored && slot_store[1] && !soft_reset |=> slot[1].overwrite)
    else $error("overwrite not flagged");
  overwrite_one_a: assert property (
    slot[0].stored && slot_store[0] && !soft_reset |=> slot[0].overwrite)
    else $error("overwrite one not flagged");
  overwrite_none_a: assert property (
    slot_store[0] && !slot[0].stored && !soft_reset |=> !slot[0].overwrite)
    else $error("overwrite one flagged without an unread result");
  flag_pair_a: assert property (slot[0].overwrite |-> slot[0].stored)
    else $error("overwrite flag set without a stored result");
  overwrite_clear_a: assert property (
    slot_read[1] && !slot_store[1] |=> !slot[1].overwrite)
    else $error("overwrite not cleared by read");
  overwrite_clear_one_a: assert property (
    slot_read[0] && !slot_store[0] |=> !slot[0].overwrite)
    else $error("overwrite one not cleared by read");
  store_wins_a: assert property (
    slot_store[2] && slot_read[2] && slot[2].stored && !soft_reset
    |=> slot[2].overwrite && slot[2].stored)
    else $error("read cleared a coincident overwrite");

  // Stored flag cleared by a read of the value field
  stored_clear_a: assert property (
    slot_read[0] && !slot_store[0] && !soft_reset |=> !slot[0].stored)
    else $error("stored flag not cleared by read");
  stored_clear_three_a: assert property (
    slot_read[2] && !slot_store[2] && !soft_reset |=> !slot[2].stored)
    else $error("stored flag three not cleared by read");

  // Read data: fields in place, reserved bits zero, idle bus zero
  read_data_a: assert property (
    reg_rd && reg_addr == ADCRR_SLOT_ONE_ADDR
    |=> reg_rdata[15:6] == $past(slot[0].value) && reg_rdata[31:16] == 16'h0000
    && reg_rdata[5:2] == 4'h0)
    else $error("slot read data wrong");
  read_data_two_a: assert property (
    reg_rd && reg_addr == ADCRR_SLOT_TWO_ADDR
    |=> reg_rdata[15:6] == $past(slot[1].value))
    else $error("slot two read data wrong");
  read_flags_a: assert property (
    reg_rd && reg_addr == ADCRR_SLOT_THREE_ADDR
    |=> reg_rdata[1] == $past(slot[2].overwrite) && reg_rdata[0] == $past(slot[2].stored))
    else $error("slot three read flags wrong");
  read_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");

  // Soft reset sequence and its effect
  soft_reset_a: assert property (
    soft_reset |=> slot[0] == '0 && slot[1] == '0 && slot[2] == '0 && !irq)
    else $error("soft reset did not clear slots");
  soft_mask_a: assert property (soft_reset |=> irq_status == '0 && irq_mask == '0)
    else $error("soft reset did not clear interrupt state");
  arm_set_a: assert property (
    reg_wr && reg_addr == ADCRR_SOFT_RESET_ADDR && reg_wdata[1:0] == ADCRR_SRST_ARM
    |=> srst_armed)
    else $error("soft reset not armed by first step");
  arm_drop_a: assert property (
    reg_wr && reg_addr == ADCRR_SOFT_RESET_ADDR && reg_wdata[1:0] != ADCRR_SRST_ARM
    |=> !srst_armed)
    else $error("soft reset stayed armed");
  no_fire_a: assert property (
    !srst_armed && !slot_store[0] && !slot_read[0] |=> $stable(slot[0]))
    else $error("slot changed without cause");

  // Interrupt: sticky status and level output
  status_set_a: assert property (slot_store[1] && !soft_reset |=> irq_status[1])
    else $error("status bit not set by a store");
  irq_level_a: assert property (irq == |(irq_status & irq_mask))
    else $error("interrupt level does not follow status and mask");

  // Main scenarios reached
  overrun_c: cover property (slot_store[0] ##1 slot_store[0] ##1 slot_read[0]);
  read_clear_c: cover property (slot_store[1] ##[1:4] slot_read[1]);
  store_read_c: cover property (slot_store[2] && slot_read[2] && slot[2].stored);
  srst_c: cover property (srst_armed ##0 soft_reset);
  irq_c: cover property (irq);
endmodule : adcrr_bank

// ### adcrr_pkg.sv
// Package for the converter result slot register bank.
// Shared by the bank module and its testbench; no clocks or resets here.
package adcrr_pkg;
  // Register byte addresses
  localparam logic [7:0] ADCRR_SLOT_ONE_ADDR = 8'h00;
  localparam logic [7:0] ADCRR_SLOT_TWO_ADDR = 8'h04;
  localparam logic [7:0] ADCRR_SLOT_THREE_ADDR = 8'h08;
  localparam logic [7:0] ADCRR_SOFT_RESET_ADDR = 8'h0C;
  localparam logic [7:0] ADCRR_IRQ_STATUS_ADDR = 8'h10;
  localparam logic [7:0] ADCRR_IRQ_MASK_ADDR = 8'h14;
  // Slot field positions
  localparam int ADCRR_VALUE_LSB = 6;
  localparam int ADCRR_VALUE_MSB = 15;
  localparam int ADCRR_OVERWRITE_BIT = 1;
  localparam int ADCRR_STORED_BIT = 0;
  localparam int ADCRR_VALUE_W = 10;
  // Soft reset field codes, first and second step
  localparam logic [1:0] ADCRR_SRST_ARM = 2'h2;
  localparam logic [1:0] ADCRR_SRST_FIRE = 2'h1;
  // Reset values
  localparam logic [31:0] ADCRR_SLOT_RESET = 32'h0000_0000;
  localparam logic [2:0] ADCRR_IRQ_RESET = 3'h0;
  // One stored result slot
  typedef struct packed {
    logic [ADCRR_VALUE_W-1:0] value;
    logic overwrite;
    logic stored;
  } adcrr_slot_t;
  // Store request from the sequencer
  typedef struct packed {
    logic store;
    logic [ADCRR_VALUE_W-1:0] value;
  } adcrr_store_t;
endpackage : adcrr_pkg

// ### adcrr_seq_model.sv
// Sequencer model: posts conversion results into the bank's store ports.
// Assumes the bank samples each store strobe on the rising edge of sys_clk.
`timescale 1ns/1ps
module adcrr_seq_model (
  // Clock
  input wire logic sys_clk,
  // Store ports toward the bank
  output adcrr_pkg::adcrr_store_t store_out [3]
);
  import adcrr_pkg::*;
  // Idle ports carry no strobe
  initial
  begin
    foreach (store_out[k]) store_out[k] = '0;
  end
  // One-cycle store strobe; value inverted once released
  task automatic post(input int k, input logic [9:0] v);
  begin
    store_out[k] <= '{store: 1'b1, value: v};
    @(posedge sys_clk);
    store_out[k] <= '{store: 1'b0, value: ~v};
  end
  endtask : post
endmodule : adcrr_seq_model

// ### tb.sv
// Testbench for the result slot bank: reads, stores, overruns, interrupt, soft reset.
// Assumes the sequencer model drives the store ports.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %0t got=%h exp=%h", $time, g, e); end end
module tb;
  import adcrr_pkg::*;
  // Bench signals
  logic sys_clk;
  logic resetn;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic irq;
  adcrr_store_t store_in [3];
  int errors;
  int n_compared;
  logic [7:0] slot_addr [3] = '{ADCRR_SLOT_ONE_ADDR, ADCRR_SLOT_TWO_ADDR, ADCRR_SLOT_THREE_ADDR};
  logic [9:0] vals [3] = '{10'h3FF, 10'h200, 10'h001};
  // Device and sequencer model
  adcrr_bank i_dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .store_in(store_in), .irq(irq));
  adcrr_seq_model i_seq (.sys_clk(sys_clk), .store_out(store_in));
  // 100 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Register write, one-cycle strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
  begin
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  end
  endtask : wr
  // Register read, data judged in the following cycle
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
  begin
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  end
  endtask : rdc
  // One result through the sequencer model
  task automatic put(input int k, input logic [9:0] v);
  begin
    @(posedge sys_clk);
    i_seq.post(k, v);
  end
  endtask : put
  // Expected slot word
  function automatic logic [31:0] sw(input logic [9:0] v, input logic o, input logic s);
    return {16'h0000, v, 4'h0, o, s};
  endfunction : sw
  // Reset values, ignored slot write, unmapped read
  task automatic t_reset;
  begin
    foreach (slot_addr[k]) rdc(slot_addr[k], ADCRR_SLOT_RESET);
    rdc(ADCRR_IRQ_MASK_ADDR, 32'h0000_0000);
    wr(ADCRR_SLOT_ONE_ADDR, 32'hFFFF_FFFF);
    rdc(ADCRR_SLOT_ONE_ADDR, ADCRR_SLOT_RESET);
    rdc(8'h20, 32'h0000_0000);
    $display("t_reset end");
  end
  endtask : t_reset
  // Store into every slot, read twice
  task automatic t_store;
  begin
    for (int k = 0; k < 3; k++)
    begin
      put(k, vals[k]);
      rdc(slot_addr[k], sw(vals[k], 1'b0, 1'b1));
      rdc(slot_addr[k], sw(vals[k], 1'b0, 1'b0));
    end
    $display("t_store end");
  end
  endtask : t_store
  // Overwrite before read, then clear on read
  task automatic t_over;
  begin
    put(0, 10'h155);
    put(0, 10'h2AA);
    rdc(ADCRR_SLOT_ONE_ADDR, sw(10'h2AA, 1'b1, 1'b1));
    rdc(ADCRR_SLOT_ONE_ADDR, sw(10'h2AA, 1'b0, 1'b0));
    put(1, 10'h0AA);
    put(1, 10'h355);
    rdc(ADCRR_SLOT_TWO_ADDR, sw(10'h355, 1'b1, 1'b1));
    rdc(ADCRR_SLOT_TWO_ADDR, sw(10'h355, 1'b0, 1'b0));
    $display("t_over end");
  end
  endtask : t_over
  // Interrupt raised masked, unmasked, then cleared
  task automatic t_irq;
  begin
    wr(ADCRR_IRQ_STATUS_ADDR, 32'h0000_0007);
    rdc(ADCRR_IRQ_STATUS_ADDR, 32'h0000_0000);
    put(1, 10'h0F0);
    rdc(ADCRR_IRQ_STATUS_ADDR, 32'h0000_0002);
    `CHK(irq, 1'b0)
    wr(ADCRR_IRQ_MASK_ADDR, 32'h0000_0002);
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(irq, 1'b1)
    wr(ADCRR_IRQ_STATUS_ADDR, 32'h0000_0002);
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(irq, 1'b0)
    $display("t_irq end");
  end
  endtask : t_irq
  // Soft reset: disarmed sequence, then full sequence
  task automatic t_soft;
  begin
    put(2, 10'h123);
    wr(ADCRR_SOFT_RESET_ADDR, 32'(ADCRR_SRST_ARM));
    wr(ADCRR_SOFT_RESET_ADDR, 32'h0000_0000);
    wr(ADCRR_SOFT_RESET_ADDR, 32'(ADCRR_SRST_FIRE));
    rdc(ADCRR_SLOT_THREE_ADDR, sw(10'h123, 1'b0, 1'b1));
    wr(ADCRR_SOFT_RESET_ADDR, 32'(ADCRR_SRST_ARM));
    wr(ADCRR_SOFT_RESET_ADDR, 32'(ADCRR_SRST_FIRE));
    rdc(ADCRR_SLOT_TWO_ADDR, ADCRR_SLOT_RESET);
    rdc(ADCRR_IRQ_MASK_ADDR, 32'h0000_0000);
    $display("t_soft end");
  end
  endtask : t_soft
  // Store and read of one slot in the same cycle: store wins
  task automatic t_same;
  begin
    fork
      put(2, 10'h2C3);
      rdc(ADCRR_SLOT_THREE_ADDR, ADCRR_SLOT_RESET);
    join
    fork
      put(2, 10'h111);
      rdc(ADCRR_SLOT_THREE_ADDR, sw(10'h2C3, 1'b0, 1'b1));
    join
    rdc(ADCRR_SLOT_THREE_ADDR, sw(10'h111, 1'b1, 1'b1));
    rdc(ADCRR_SLOT_THREE_ADDR, sw(10'h111, 1'b0, 1'b0));
    $display("t_same end");
  end
  endtask : t_same
  // Counts and verdict
  task automatic report_and_stop;
  begin
    $display("compared=%0d errors=%0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask : report_and_stop
  // Watchdog
  initial
  begin
    #20us;
    errors++;
    report_and_stop;
  end
  // Main sequence
  initial
  begin
    errors = 0;
    n_compared = 0;
    resetn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset;
    t_store;
    t_over;
    t_irq;
    t_soft;
    t_same;
    report_and_stop;
  end
endmodule : tb
